// ==== twb_fifo2.sv ====
// Purpose: shared constants and the two-entry receive buffer
// Assumes: one clock, synchronous active-low reset
// Notes: buffer outputs come straight from flip-flops
`timescale 1ns/1ps
package twb_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int LEN_W = 4;
  localparam int BIT_W = 4;
  localparam logic [BIT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [BIT_W-1:0] BIT_ACK = 4'h8;
  localparam logic [BIT_W-1:0] BIT_PRE = 4'hF;
  localparam logic [ADDR_W-1:0] GC_ADDR = 7'h00;
  localparam logic [3:0] RSV_TOP = 4'hF;
  localparam logic [LEN_W-1:0] LEN_ONE = 4'h1;
  localparam logic [LEN_W-1:0] LEN_NONE = 4'h0;
  localparam int CLK_NS = 50;
  localparam int SCL_HALF_NS = 5000;
  localparam int HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TM_W = 8;
  localparam logic [TM_W-1:0] HALF_T = TM_W'(HALF_CYC);
endpackage

////////////////////////////////////////////////////////////////////////////////
module twb_fifo2 #(
  parameter int W = twb_pkg::BYTE_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  import twb_pkg::*;
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic hv;
    logic tv;
  } twb_f_s;
  twb_f_s st_q;
  twb_f_s st_d;
  logic pop;
  logic push;

  // a full buffer refuses even when popping, so ready stays a plain flop
  always_comb begin
    st_d = st_q;
    pop = st_q.hv && out_ready_i;
    push = in_valid_i && !st_q.tv;
    if (pop) begin
      st_d.head = st_q.tail;
      st_d.hv = st_q.tv;
      st_d.tv = 1'b0;
    end
    if (push) begin
      if (!st_d.hv) begin
        st_d.head = in_data_i;
        st_d.hv = 1'b1;
      end else begin
        st_d.tail = in_data_i;
        st_d.tv = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_o = !st_q.tv;
  assign out_data_o = st_q.head;
  assign out_valid_o = st_q.hv;
endmodule

// ==== twb_framer.sv ====
// Purpose: two-wire bus framing engine, master and slave, tx and rx
// Assumes: bus pins open drain, lines sampled on the 20 MHz clock
// Notes: no arbitration; one bus role at a time
// Contract
// - data stable while clock high
// - master signals start/stop with clock high
// - bus busy from start until stop
// - repeated start keeps bus busy
// - address packet: seven bits, direction, acknowledge
// - direction set means read, clear write
// - addressed slave pulls ninth bit low
// - unacknowledged address ends in stop
// - address shifted most significant bit first
// - general call write acknowledged when enabled
// - addresses 1111xxx are reserved
// - data packet: byte then acknowledge bit
// - master clocks, receiver acknowledges
// - ninth bit low acknowledges, high refuses
// - receiver refuses its last byte
// - start, address, data packets, stop
// - slave may stretch clock low
// - open-drain drivers, wired-AND lines
// - disabled while power gate set
// - seven-bit programmable slave address
`timescale 1ns/1ps
module twb_framer (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SERIAL_BUS_POWER_GATE_I,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [twb_pkg::ADDR_W-1:0] OWN_ADDR_I,
  input wire logic GC_EN_I,
  input wire logic RX_ACCEPT_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic [twb_pkg::ADDR_W-1:0] CMD_ADDR_I,
  input wire logic CMD_READ_I,
  input wire logic [twb_pkg::LEN_W-1:0] CMD_LEN_I,
  output logic DONE_O,
  output logic NACK_O,
  output logic BUS_BUSY_O,
  output logic SLV_SEL_O,
  input wire logic [twb_pkg::BYTE_W-1:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  output logic [twb_pkg::BYTE_W-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I
);
  import twb_pkg::*;

  typedef enum logic [3:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_PUSH,
    M_LOAD, M_STOP, M_STOPH, M_FREE
  } twb_m_e;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_RX, S_RXW, S_TX, S_TXW, S_REL, S_IGN
  } twb_s_e;
  typedef enum logic [1:0] {P_ADDR, P_WR, P_RD} twb_p_e;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_p;
    logic sda_p;
    logic busy;
    twb_m_e ms;
    twb_s_e ss;
    twb_p_e ph;
    logic [BIT_W-1:0] bitn;
    logic [BYTE_W-1:0] sh;
    logic [TM_W-1:0] tm;
    logic [LEN_W-1:0] left;
    logic rd;
    logic srd;
    logic sack;
    logic nxt;
    logic scl_oe;
    logic sda_oe;
    logic lvl;
    logic cmd_rdy;
    logic tx_rdy;
    logic done;
    logic nack;
    logic sel;
  } twb_st_s;

  twb_st_s st_q;
  twb_st_s st_d;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic hit;
  logic tx_take;
  logic rx_push;
  logic rx_rdy;

  ////////////////////////////////////////////////////////////////////////////
  // line observation after the two-flop synchronisers
  assign scl_s = st_q.scl_sy[1];
  assign sda_s = st_q.sda_sy[1];
  assign rise = scl_s && !st_q.scl_p;
  assign fall = !scl_s && st_q.scl_p;
  assign start_det = scl_s && st_q.scl_p && st_q.sda_p && !sda_s;
  assign stop_det = scl_s && st_q.scl_p && !st_q.sda_p && sda_s;
  // reserved block never matches; general call only with write
  assign hit = (st_q.sh[7:1] == OWN_ADDR_I && OWN_ADDR_I[6:3] != RSV_TOP)
    || (st_q.sh[7:1] == GC_ADDR && GC_EN_I && !st_q.sh[0]);
  assign tx_take = st_q.tx_rdy && TX_VALID_I;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    rx_push = 1'b0;
    st_d.scl_sy = {st_q.scl_sy[0], SCL_I};
    st_d.sda_sy = {st_q.sda_sy[0], SDA_I};
    st_d.scl_p = scl_s;
    st_d.sda_p = sda_s;
    st_d.done = 1'b0;
    st_d.nack = 1'b0;
    if (st_q.tm != '0) begin
      st_d.tm = st_q.tm - 1'b1;
    end
    if (start_det) begin
      st_d.busy = 1'b1;
    end else if (stop_det) begin
      st_d.busy = 1'b0;
    end

    // master: the timer paces both halves of every clock period
    case (st_q.ms)
      M_IDLE: begin
        if (st_q.cmd_rdy && CMD_VALID_I) begin
          // an address always follows our start
          st_d.ms = M_START;
          st_d.sda_oe = 1'b1;
          st_d.tm = HALF_T;
          st_d.sh = {CMD_ADDR_I, CMD_READ_I};
          st_d.rd = CMD_READ_I;
          st_d.left = (CMD_LEN_I == LEN_NONE) ? LEN_ONE : CMD_LEN_I;
          st_d.ph = P_ADDR;
          st_d.bitn = '0;
        end
      end
      M_START: begin
        if (st_q.tm == '0) begin
          st_d.scl_oe = 1'b1;
          st_d.nxt = !st_q.sh[7];
          st_d.tm = HALF_T;
          st_d.ms = M_LOW;
        end
      end
      M_LOW: begin
        // data moves one cycle after the clock went low
        st_d.sda_oe = st_q.nxt;
        if (st_q.tm == '0) begin
          st_d.scl_oe = 1'b0;
          st_d.tm = HALF_T;
          st_d.ms = M_HIGH;
        end
      end
      M_HIGH: begin
        if (!scl_s) begin
          // a slave holds the clock low: high time starts when seen high
          st_d.tm = HALF_T;
        end else if (st_q.tm == '0) begin
          st_d.scl_oe = 1'b1;
          st_d.tm = HALF_T;
          st_d.ms = M_LOW;
          st_d.nxt = 1'b0;
          if (st_q.bitn != BIT_ACK) begin
            st_d.bitn = st_q.bitn + 1'b1;
            st_d.sh = {st_q.sh[6:0], (st_q.ph == P_RD) ? sda_s : 1'b0};
            if (st_q.bitn == BIT_LAST) begin
              if (st_q.ph == P_RD) begin
                st_d.ms = M_PUSH;
              end
            end else if (st_q.ph != P_RD) begin
              st_d.nxt = !st_d.sh[7];
            end
          end else begin
            st_d.bitn = '0;
            if (st_q.ph == P_ADDR) begin
              if (sda_s) begin
                st_d.nack = 1'b1;
                st_d.ms = M_STOP;
              end else begin
                st_d.ph = st_q.rd ? P_RD : P_WR;
                st_d.ms = st_q.rd ? M_LOW : M_LOAD;
              end
            end else begin
              st_d.left = st_q.left - 1'b1;
              if (st_q.ph == P_WR && sda_s) begin
                st_d.nack = 1'b1;
                st_d.ms = M_STOP;
              end else if (st_q.left == LEN_ONE) begin
                st_d.ms = M_STOP;
              end else begin
                st_d.ms = (st_q.ph == P_RD) ? M_LOW : M_LOAD;
              end
            end
          end
        end
      end
      M_PUSH: begin
        // clock held low until the buffer has room: no byte lost
        if (rx_rdy) begin
          rx_push = 1'b1;
          st_d.nxt = (st_q.left != LEN_ONE);
          st_d.tm = HALF_T;
          st_d.ms = M_LOW;
        end
      end
      M_LOAD: begin
        if (tx_take) begin
          st_d.sh = TX_DATA_I;
          st_d.nxt = !TX_DATA_I[7];
          st_d.tm = HALF_T;
          st_d.ms = M_LOW;
        end
      end
      M_STOP: begin
        st_d.sda_oe = 1'b1;
        if (st_q.tm == '0) begin
          st_d.scl_oe = 1'b0;
          st_d.tm = HALF_T;
          st_d.ms = M_STOPH;
        end
      end
      M_STOPH: begin
        if (!scl_s) begin
          st_d.tm = HALF_T;
        end else if (st_q.tm == '0) begin
          st_d.sda_oe = 1'b0;
          st_d.tm = HALF_T;
          st_d.ms = M_FREE;
        end
      end
      M_FREE: begin
        if (st_q.tm == '0) begin
          st_d.ms = M_IDLE;
          st_d.done = 1'b1;
        end
      end
      default: begin
        st_d.ms = M_IDLE;
      end
    endcase

    // slave: only while our own master is idle
    if (st_q.ms != M_IDLE) begin
      st_d.ss = S_IDLE;
    end else if (start_det) begin
      st_d.ss = S_ADDR;
      st_d.bitn = BIT_PRE;
      st_d.sda_oe = 1'b0;
      st_d.scl_oe = 1'b0;
      st_d.sel = 1'b0;
    end else if (stop_det) begin
      st_d.ss = S_IDLE;
      st_d.sda_oe = 1'b0;
      st_d.scl_oe = 1'b0;
      st_d.sel = 1'b0;
    end else begin
      case (st_q.ss)
        S_ADDR, S_RX: begin
          if (rise && st_q.bitn != BIT_ACK) begin
            st_d.sh = {st_q.sh[6:0], sda_s};
          end else if (fall) begin
            if (st_q.bitn == BIT_LAST) begin
              st_d.bitn = BIT_ACK;
              if (st_q.ss == S_ADDR) begin
                if (hit) begin
                  st_d.sda_oe = 1'b1;
                  st_d.sel = 1'b1;
                  st_d.srd = st_q.sh[0];
                end else begin
                  st_d.ss = S_IGN;
                end
              end else begin
                st_d.scl_oe = 1'b1;
                st_d.ss = S_RXW;
              end
            end else if (st_q.bitn == BIT_ACK) begin
              st_d.sda_oe = 1'b0;
              st_d.bitn = '0;
              if (st_q.ss == S_ADDR && st_q.srd) begin
                st_d.scl_oe = 1'b1;
                st_d.ss = S_TXW;
              end else if (st_q.ss == S_ADDR) begin
                st_d.ss = S_RX;
              end else if (!st_q.sack) begin
                st_d.ss = S_IGN;
              end
            end else begin
              st_d.bitn = st_q.bitn + 1'b1;
            end
          end
        end
        S_RXW: begin
          if (!RX_ACCEPT_I) begin
            st_d.sack = 1'b0;
            st_d.ss = S_REL;
          end else if (rx_rdy) begin
            rx_push = 1'b1;
            st_d.sack = 1'b1;
            st_d.sda_oe = 1'b1;
            st_d.ss = S_REL;
          end
        end
        S_TXW: begin
          if (tx_take) begin
            st_d.sh = TX_DATA_I;
            st_d.sda_oe = !TX_DATA_I[7];
            st_d.bitn = '0;
            st_d.ss = S_REL;
          end
        end
        S_REL: begin
          // data settled a cycle earlier, now let the clock go
          st_d.scl_oe = 1'b0;
          st_d.ss = st_q.srd ? S_TX : S_RX;
        end
        S_TX: begin
          if (rise && st_q.bitn == BIT_ACK) begin
            st_d.sack = !sda_s;
          end else if (fall) begin
            if (st_q.bitn == BIT_ACK) begin
              st_d.bitn = '0;
              st_d.scl_oe = st_q.sack;
              st_d.ss = st_q.sack ? S_TXW : S_IGN;
            end else if (st_q.bitn == BIT_LAST) begin
              st_d.sda_oe = 1'b0;
              st_d.bitn = BIT_ACK;
            end else begin
              st_d.bitn = st_q.bitn + 1'b1;
              st_d.sh = {st_q.sh[6:0], 1'b0};
              st_d.sda_oe = !st_q.sh[6];
            end
          end
        end
        S_IGN, S_IDLE: begin
          st_d.ss = st_q.ss;
        end
        default: begin
          st_d.ss = S_IDLE;
        end
      endcase
    end

    st_d.lvl = 1'b0;
    st_d.tx_rdy = (st_d.ms == M_LOAD) || (st_d.ss == S_TXW);
    st_d.cmd_rdy = (st_d.ms == M_IDLE) && (st_d.ss == S_IDLE || st_d.ss == S_IGN)
      && !st_d.busy && scl_s && sda_s;
    if (SERIAL_BUS_POWER_GATE_I) begin
      st_d = '0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  twb_fifo2 #(
    .W(BYTE_W)
  ) u_rx_buf (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .in_data_i(st_q.sh),
    .in_valid_i(rx_push),
    .in_ready_o(rx_rdy),
    .out_data_o(RX_DATA_O),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I)
  );

  // pins only ever pull low: output level stays zero
  assign SCL_O = st_q.lvl;
  assign SDA_O = st_q.lvl;
  assign SCL_OE_O = st_q.scl_oe;
  assign SDA_OE_O = st_q.sda_oe;
  assign CMD_READY_O = st_q.cmd_rdy;
  assign TX_READY_O = st_q.tx_rdy;
  assign DONE_O = st_q.done;
  assign NACK_O = st_q.nack;
  assign BUS_BUSY_O = st_q.busy;
  assign SLV_SEL_O = st_q.sel;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  busy_on_start_a: assert property (
    start_det && !SERIAL_BUS_POWER_GATE_I |=> BUS_BUSY_O ##1 BUS_BUSY_O)
    else $error("bus not busy after start");
  busy_on_stop_a: assert property (
    stop_det && !SERIAL_BUS_POWER_GATE_I |=> !BUS_BUSY_O)
    else $error("bus still busy after stop");
  busy_holds_a: assert property (
    BUS_BUSY_O && !stop_det && !SERIAL_BUS_POWER_GATE_I |=> BUS_BUSY_O)
    else $error("busy dropped without stop");
  master_data_stable_a: assert property (
    st_q.ms == M_HIGH && $past(st_q.ms) == M_HIGH |-> $stable(SDA_OE_O))
    else $error("master data moved while clock high");
  start_shape_a: assert property (
    st_q.ms == M_IDLE ##1 st_q.ms == M_START |-> !SCL_OE_O && SDA_OE_O)
    else $error("start not made with clock high");
  stretch_wait_a: assert property (
    st_q.ms == M_HIGH && !scl_s && !SERIAL_BUS_POWER_GATE_I |=> st_q.tm == HALF_T)
    else $error("high phase counted while clock held low");
  addr_ack_a: assert property (
    st_q.ms == M_IDLE && st_q.ss == S_ADDR && fall && st_q.bitn == BIT_LAST && hit
    && !SERIAL_BUS_POWER_GATE_I |=> SDA_OE_O && SLV_SEL_O)
    else $error("matched address not acknowledged");
  reserved_addr_a: assert property (
    st_q.ms == M_IDLE && st_q.ss == S_ADDR && fall && st_q.bitn == BIT_LAST
    && OWN_ADDR_I[6:3] == RSV_TOP && st_q.sh[7:1] == OWN_ADDR_I
    && !SERIAL_BUS_POWER_GATE_I |=> !SDA_OE_O)
    else $error("reserved address acknowledged");
  last_byte_nack_a: assert property (
    st_q.ms == M_PUSH && rx_rdy && st_q.left == LEN_ONE
    && !SERIAL_BUS_POWER_GATE_I |=> st_q.ms == M_LOW ##1 !SDA_OE_O)
    else $error("last read byte acknowledged");
  addr_nack_stop_a: assert property (
    st_q.ms == M_HIGH && st_q.bitn == BIT_ACK && st_q.ph == P_ADDR && st_q.tm == '0
    && scl_s && sda_s && !SERIAL_BUS_POWER_GATE_I |=> st_q.ms == M_STOP && NACK_O)
    else $error("no stop after refused address");
  gated_idle_a: assert property (
    SERIAL_BUS_POWER_GATE_I |=> !SCL_OE_O && !SDA_OE_O && !CMD_READY_O)
    else $error("interface active while gated");

  write_done_c: cover property (st_q.ms == M_FREE && st_q.ph == P_WR ##1 DONE_O);
  read_done_c: cover property (st_q.ms == M_FREE && st_q.ph == P_RD ##1 DONE_O);
  slave_hit_c: cover property ($rose(SLV_SEL_O));
  rstart_c: cover property (start_det && BUS_BUSY_O);
  rx_stretch_c: cover property (st_q.ss == S_RXW [*3]);
endmodule

// ==== twb_peer.sv ====
// Purpose: far-side bus peer, slave to the block's master and master to its slave
// Assumes: the bench resolves both lines as wired-AND with pull-ups
// Notes: mastering uses a 400 ns bus clock; slave timing is behavioural
`timescale 1ns/1ps
module twb_peer #(
  parameter logic [6:0] ADDR = 7'h3A
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  int lim = 8;
  int stretch_ns = 0;
  int nrd = 0;
  int stall = 0;
  logic mst = 1'b0;
  logic [7:0] got[$];
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic get_byte(output logic [7:0] b);
    repeat (8) begin
      @(posedge scl_i);
      b = {b[6:0], sda_i};
    end
  endtask
  // ends just after the falling clock that closes the ack slot
  task automatic ack(input logic a);
    @(negedge scl_i);
    #100 sda_oe_o = a;
    if (stretch_ns > 0) begin
      scl_oe_o = 1'b1;
      #(stretch_ns) scl_oe_o = 1'b0;
    end
    @(posedge scl_i);
    @(negedge scl_i);
  endtask
  task automatic slv_body();
    logic [7:0] b;
    logic ok;
    get_byte(b);
    if (b[7:1] != ADDR)
      return;
    ack(1'b1);
    if (b[0]) begin
      ok = 1'b1;
      while (ok) begin
        b = 8'hC0 + 8'(nrd);
        for (int i = 7; i >= 0; i--) begin
          #100 sda_oe_o = ~b[i];
          @(posedge scl_i);
          @(negedge scl_i);
        end
        #100 sda_oe_o = 1'b0;
        nrd++;
        @(posedge scl_i);
        ok = !sda_i;
        @(negedge scl_i);
      end
    end else begin
      forever begin
        #100 sda_oe_o = 1'b0;
        get_byte(b);
        got.push_back(b);
        ack(got.size() < lim);
      end
    end
  endtask
  // a stop ends whatever the slave side was doing
  always @(negedge sda_i) begin
    if (scl_i && !mst) begin
      fork
        slv_body();
        @(posedge sda_i iff scl_i);
      join_any
      disable fork;
      sda_oe_o = 1'b0;
      scl_oe_o = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // low phase then high phase; a held-low clock is waited for, but not forever
  task automatic m_half(input logic v);
    int n;
    #50 sda_oe_o = ~v;
    #150 scl_oe_o = 1'b0;
    n = 0;
    while (!scl_i && n < 4000) begin
      #50 n++;
    end
    if (!scl_i)
      stall++;
    #200;
  endtask
  task automatic m_bit(input logic v, output logic r);
    m_half(v);
    r = sda_i;
    scl_oe_o = 1'b1;
  endtask
  task automatic m_byte(input logic [7:0] v, input logic ackv, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      m_bit(v[i], r[i]);
    m_bit(ackv, a);
  endtask
  task automatic m_start();
    mst = 1'b1;
    m_half(1'b1);
    sda_oe_o = 1'b1;
    #200 scl_oe_o = 1'b1;
  endtask
  task automatic m_stop();
    m_half(1'b0);
    sda_oe_o = 1'b0;
    #400 mst = 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for the two-wire framer in both bus roles
// Assumes: peer model on the far side, lines pulled up
// Notes: ordinary master transfers come from a row table
`timescale 1ns/1ps
module tb_top;
  import twb_pkg::*;
  localparam logic [ADDR_W-1:0] PEER_A = 7'h3A;
  localparam logic [ADDR_W-1:0] OWN_A = 7'h51;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic rd;
    logic [LEN_W-1:0] len;
    logic [7:0] lim;
    logic [15:0] str;
    logic nk;
    logic [7:0] n;
  } twb_row_s;
  typedef struct packed {
    logic [7:0] ab;
    logic [ADDR_W-1:0] own;
    logic gc;
    logic acc;
    logic gate;
    logic [7:0] acks;
  } twb_probe_s;
  twb_row_s rows[5] = '{
    '{PEER_A, 1'b0, 4'h2, 8'h08, 16'h0000, 1'b0, 8'h02},
    '{PEER_A, 1'b1, 4'h3, 8'h08, 16'h0000, 1'b0, 8'h03},
    '{7'h2A, 1'b0, 4'h1, 8'h08, 16'h0000, 1'b1, 8'h00},
    '{PEER_A, 1'b0, 4'h0, 8'h08, 16'h4E20, 1'b0, 8'h01},
    '{PEER_A, 1'b0, 4'h3, 8'h02, 16'h0000, 1'b1, 8'h02}};
  twb_probe_s probes[6] = '{
    '{8'h00, OWN_A, 1'b1, 1'b1, 1'b0, 8'hFC},
    '{8'h00, OWN_A, 1'b0, 1'b1, 1'b0, 8'hFF},
    '{8'h01, OWN_A, 1'b1, 1'b1, 1'b0, 8'hFF},
    '{8'hF4, 7'h7A, 1'b0, 1'b1, 1'b0, 8'hFF},
    '{8'hA2, OWN_A, 1'b0, 1'b0, 1'b0, 8'hFE},
    '{8'hA2, OWN_A, 1'b0, 1'b1, 1'b1, 8'hFF}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gate = 1'b0;
  logic gc_en = 1'b0;
  logic accept = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic tx_en = 1'b0;
  logic rx_rdy = 1'b1;
  logic [ADDR_W-1:0] own = OWN_A;
  logic [ADDR_W-1:0] cmd_addr = 7'h00;
  logic [LEN_W-1:0] cmd_len = 4'h0;
  logic [BYTE_W-1:0] tx_byte = 8'h10;
  logic scl_oe, sda_oe, p_scl, p_sda, cmd_ready, done, nack, busy, sel, tx_ready, rx_valid;
  logic scl_lvl, sda_lvl;
  logic [BYTE_W-1:0] rx_data;
  logic [7:0] rx_q[$];
  logic [7:0] sq[$];
  int fails = 0;
  int num_checks = 0;
  wire scl = !(scl_oe || p_scl);
  wire sda = !(sda_oe || p_sda);
  always #25 clk = ~clk;
  twb_framer dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .SERIAL_BUS_POWER_GATE_I(gate), .SCL_I(scl),
    .SCL_O(scl_lvl), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_lvl), .SDA_OE_O(sda_oe), .OWN_ADDR_I(own),
    .GC_EN_I(gc_en),
    .RX_ACCEPT_I(accept), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_ADDR_I(cmd_addr),
    .CMD_READ_I(cmd_read), .CMD_LEN_I(cmd_len), .DONE_O(done), .NACK_O(nack), .BUS_BUSY_O(busy),
    .SLV_SEL_O(sel), .TX_DATA_I(tx_byte), .TX_VALID_I(tx_en), .TX_READY_O(tx_ready), .RX_DATA_O(rx_data),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_rdy));
  twb_peer #(.ADDR(PEER_A)) peer (.scl_i(scl), .sda_i(sda), .scl_oe_o(p_scl), .sda_oe_o(p_sda));
  // streams: pops seen at the edge, next byte offered just after it
  always @(posedge clk) begin
    if (rx_valid && rx_rdy)
      rx_q.push_back(rx_data);
    if (tx_en && tx_ready)
      tx_byte <= #1 tx_byte + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tmo(input string m);
    fails++;
    $display("FAIL %0t timeout %s", $time, m);
    summarize();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mcmd(input twb_row_s r, output logic nk);
    int n;
    logic bz;
    n = 0;
    nk = 1'b0;
    bz = 1'b0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    if (n >= 4000)
      tmo("ready");
    cmd_addr = r.a;
    cmd_read = r.rd;
    cmd_len = r.len;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      cyc(1);
      n++;
      nk = nk | (nack === 1'b1);
      bz = bz | (busy === 1'b1);
    end
    if (n >= 40000)
      tmo("done");
    chk(bz, 1'b1, "busy in transfer");
    chk(busy, 1'b0, "free after done");
  endtask
  // peer masters the block's slave side; acks bit i belongs to packet i
  task automatic sx(input logic [7:0] ab, input int nb, output logic [7:0] acks);
    logic [7:0] r;
    logic a;
    acks = 8'hFF;
    sq.delete();
    peer.m_start();
    peer.m_byte(ab, 1'b1, r, a);
    acks[0] = a;
    for (int i = 1; i <= nb && !a; i++) begin
      peer.m_byte(ab[0] ? 8'hFF : 8'hA0 + 8'(i), ab[0] ? (i == nb) : 1'b1, r, a);
      acks[i] = a;
      if (ab[0])
        sq.push_back(r);
    end
    peer.m_stop();
    cyc(5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic nk;
    logic [7:0] t0, acks;
    cyc(19);
    chk({4'h0, scl_oe, sda_oe, cmd_ready, busy}, 8'h00, "outputs in reset");
    cyc(1);
    rst_n = 1'b1;
    tx_en = 1'b1;
    foreach (rows[i]) begin
      peer.lim = int'(rows[i].lim);
      peer.stretch_ns = int'(rows[i].str);
      peer.nrd = 0;
      peer.got.delete();
      rx_q.delete();
      t0 = tx_byte;
      mcmd(rows[i], nk);
      cyc(10);
      chk(nk, rows[i].nk, "nack pulse");
      if (rows[i].rd) begin
        chk(8'(peer.nrd), rows[i].n, "bytes read");
        chk(8'(rx_q.size()), rows[i].n, "bytes buffered");
        foreach (rx_q[k]) chk(rx_q[k], 8'hC0 + 8'(k), "read byte");
      end else begin
        chk(8'(peer.got.size()), rows[i].n, "bytes written");
        foreach (peer.got[k]) chk(peer.got[k], t0 + 8'(k), "written byte");
      end
    end
    peer.stretch_ns = 0;
    rx_q.delete();
    rx_rdy = 1'b0;
    fork
      sx({OWN_A, 1'b0}, 4, acks);
      begin
        cyc(1500);
        chk({6'h0, sel, rx_valid}, 8'h03, "held while buffer full");
        chk(8'(rx_q.size()), 8'h00, "no pop while stalled");
        chk({6'h0, scl_lvl, sda_lvl}, 8'h00, "pins only pull low");
        rx_rdy = 1'b1;
      end
    join
    chk(acks, 8'hE0, "slave write acks");
    chk(8'(rx_q.size()), 8'h04, "slave rx count");
    foreach (rx_q[k]) chk(rx_q[k], 8'hA1 + 8'(k), "slave rx byte");
    t0 = tx_byte;
    sx({OWN_A, 1'b1}, 2, acks);
    chk(acks, 8'hFC, "slave read acks");
    chk(8'(sq.size()), 8'h02, "slave tx count");
    foreach (sq[k]) chk(sq[k], t0 + 8'(k), "slave tx byte");
    foreach (probes[i]) begin
      own = probes[i].own;
      gc_en = probes[i].gc;
      accept = probes[i].acc;
      gate = probes[i].gate;
      cyc(4);
      sx(probes[i].ab, 1, acks);
      chk(acks, probes[i].acks, "probe acks");
    end
    gate = 1'b0;
    own = OWN_A;
    accept = 1'b1;
    cyc(4);
    peer.m_start();
    peer.m_byte({7'h2A, 1'b0}, 1'b1, t0, nk);
    chk(nk, 1'b1, "foreign address");
    peer.m_start();
    chk(busy, 1'b1, "busy over repeated start");
    peer.m_byte({OWN_A, 1'b0}, 1'b1, t0, nk);
    chk(nk, 1'b0, "own after repeated start");
    peer.m_stop();
    cyc(5);
    chk(busy, 1'b0, "free after stop");
    chk(8'(peer.stall), 8'h00, "clock released in time");
    // second reset while idle: outputs clear at once, ready returns after the syncs
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk({4'h0, scl_oe, sda_oe, cmd_ready, busy}, 8'h00, "outputs after mid-run reset");
    cyc(10);
    chk(cmd_ready, 1'b1, "ready after mid-run reset");
    summarize();
  end
endmodule
